// ### shared/bdio_pkg.sv
package bdio_pkg;
  // Register addresses on the plain register port
  localparam logic [3:0] WIDE_DATA_ADDR     = 4'h0;
  localparam logic [3:0] WIDE_DIR_ADDR      = 4'h1;
  localparam logic [3:0] NARROW_DATA_ADDR   = 4'h2;
  localparam logic [3:0] NARROW_DIR_ADDR    = 4'h3;
  localparam logic [3:0] WIDE_ANALOG_ADDR   = 4'h4;
  localparam logic [3:0] NARROW_ANALOG_ADDR = 4'h5;
  localparam logic [3:0] PWM_SEL_ADDR       = 4'h6;

  // Widths and field positions
  localparam int WIDE_W        = 8;
  localparam int NARROW_W      = 4;
  localparam int INPUT_ONLY_BIT = 3;
  localparam int PWM_FIRST_BIT = 5;
  localparam int PWM_W         = 3;

  // Values after reset
  localparam logic [7:0] WIDE_DIR_RST     = 8'hff;
  localparam logic [3:0] NARROW_DIR_RST   = 4'hf;
  localparam logic [7:0] WIDE_LATCH_RST   = 8'h00;
  localparam logic [3:0] NARROW_LATCH_RST = 4'h0;
  localparam logic [7:0] WIDE_ANALOG_RST  = 8'hff;
  localparam logic [3:0] NARROW_ANALOG_RST = 4'hf;
  localparam logic [2:0] PWM_SEL_RST      = 3'h0;

  // Synchroniser depth in cycles
  localparam int SYNC_STAGES = 2;
endpackage : bdio_pkg

// ### logic/bdio_sync.sv
module bdio_sync #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic             clk_sys_in,
  input  wire logic             rst_n_in,
  // Raw and synchronised levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] sync_next;

  // Two stages; first stage feeds only the second
  always_comb begin
    meta_next = async_in;
    sync_next = meta_reg;
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
    end
  end

  assign sync_out = sync_reg;
endmodule : bdio_sync

// ### logic/bdio_ports.sv
// Summary of operation
// - Direction bit one puts that wide pin's driver in high impedance.
// - Direction bit zero drives the wide pin from its output latch bit.
// - Data reads return pin levels; data writes update only the latch.
// - Writes sample pins, merge the change, store result into latch.
// - Direction bits gate drivers even on analog pins; software keeps them set.
// - Pins selected as analog read back zero in the data register.
// - Wide port has eight pins, each with direction and data bit.
// - Full reset: direction all ones; warm reset keeps latch, direction ones.
// - Narrow port has four pin positions behaving like the wide port.
// - Narrow bit three is input only; its direction bit reads one.
// - With master clear enabled, input-only pin data bit reads zero.
// - Unimplemented bits, like narrow data bits seven to four, read zero.
// - Data bit follows pin logic level above/below input thresholds.
// - Wide pins four to zero are plain general purpose I/O.
// - Wide pins five to seven select I/O or PWM outputs B, C, D.
//
// Chosen here: the placing of the registers and the address-and-strobe port.
module bdio_ports (
  // Clock and resets
  input  wire logic       clk_sys_in,
  input  wire logic       rst_n_in,
  input  wire logic       full_reset_n_in,
  // Register port
  input  wire logic [3:0] reg_addr_in,
  input  wire logic [7:0] reg_wdata_in,
  input  wire logic       reg_wr_in,
  input  wire logic       reg_rd_in,
  output logic      [7:0] reg_rdata_out,
  // Configuration
  input  wire logic       master_clear_pin_enable_in,
  // PWM sources
  input  wire logic       pwm_output_b_in,
  input  wire logic       pwm_output_c_in,
  input  wire logic       pwm_output_d_in,
  // Wide port pins
  input  wire logic [7:0] wide_pin_in,
  output logic      [7:0] wide_pin_out,
  output logic      [7:0] wide_pin_oe_out,
  // Narrow port pins
  input  wire logic [3:0] narrow_pin_in,
  output logic      [2:0] narrow_pin_out,
  output logic      [2:0] narrow_pin_oe_out
);
  logic [7:0] wide_dir_reg;
  logic [7:0] wide_dir_next;
  logic [7:0] wide_latch_reg;
  logic [7:0] wide_latch_next;
  logic [3:0] narrow_dir_reg;
  logic [3:0] narrow_dir_next;
  logic [3:0] narrow_latch_reg;
  logic [3:0] narrow_latch_next;
  logic [7:0] wide_analog_reg;
  logic [7:0] wide_analog_next;
  logic [3:0] narrow_analog_reg;
  logic [3:0] narrow_analog_next;
  logic [2:0] pwm_sel_reg;
  logic [2:0] pwm_sel_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic [7:0] wide_sync;
  logic [3:0] narrow_sync;
  logic [7:0] wide_view;
  logic [3:0] narrow_view;
  logic [7:0] wide_drive;
  logic [2:0] pwm_src;
  logic [7:0] narrow_full_view;
  logic [7:0] wide_merge;
  logic [7:0] narrow_merge;
  logic [7:0] wide_oe;
  logic [2:0] narrow_drive;
  logic [2:0] narrow_oe;
  // Decoded one-cycle strobes
  logic       wr_wide_data;
  logic       wr_wide_dir;
  logic       wr_narrow_data;
  logic       wr_narrow_dir;
  logic       wr_wide_analog;
  logic       wr_narrow_analog;
  logic       wr_pwm_sel;
  logic       rd_wide_data;
  logic       rd_wide_dir;
  logic       rd_narrow_data;
  logic       rd_narrow_dir;
  logic       rd_wide_analog;
  logic       rd_narrow_analog;
  logic       rd_pwm_sel;

  // Pin level mask for digital reads
  function automatic logic [7:0] bdio_digital_view(input logic [7:0] lvl,
                                                   input logic [7:0] ana);
    bdio_digital_view = lvl & ~ana;
  endfunction : bdio_digital_view

  // Address match, shared by the write and read decoders
  function automatic logic bdio_hit(input logic [3:0] addr,
                                    input logic [3:0] target);
    bdio_hit = (addr == target);
  endfunction : bdio_hit

  // Merge write data into sampled pins; set keep bits hold the pin
  function automatic logic [7:0] bdio_merge(input logic [7:0] pins,
                                            input logic [7:0] data,
                                            input logic [7:0] keep);
    bdio_merge = (pins & keep) | (data & ~keep);
  endfunction : bdio_merge

  // Synchronise pins before use
  bdio_sync #(.WIDTH(bdio_pkg::WIDE_W)) u_wide_sync (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .async_in   (wide_pin_in),
    .sync_out   (wide_sync)
  );

  bdio_sync #(.WIDTH(bdio_pkg::NARROW_W)) u_narrow_sync (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .async_in   (narrow_pin_in),
    .sync_out   (narrow_sync)
  );

  // Pin views seen by reads and read-modify-write
  always_comb begin
    wide_view        = bdio_digital_view(wide_sync, wide_analog_reg);
    narrow_full_view = bdio_digital_view({4'h0, narrow_sync},
                                         {4'h0, narrow_analog_reg});
    narrow_view      = narrow_full_view[3:0];
    if (master_clear_pin_enable_in) begin
      narrow_view[bdio_pkg::INPUT_ONLY_BIT] = 1'b0;
    end
  end

  // Write strobes, one per register; unmapped addresses match none
  always_comb begin
    wr_wide_data     = reg_wr_in && bdio_hit(reg_addr_in, bdio_pkg::WIDE_DATA_ADDR);
    wr_wide_dir      = reg_wr_in && bdio_hit(reg_addr_in, bdio_pkg::WIDE_DIR_ADDR);
    wr_narrow_data   = reg_wr_in && bdio_hit(reg_addr_in, bdio_pkg::NARROW_DATA_ADDR);
    wr_narrow_dir    = reg_wr_in && bdio_hit(reg_addr_in, bdio_pkg::NARROW_DIR_ADDR);
    wr_wide_analog   = reg_wr_in && bdio_hit(reg_addr_in, bdio_pkg::WIDE_ANALOG_ADDR);
    wr_narrow_analog = reg_wr_in && bdio_hit(reg_addr_in, bdio_pkg::NARROW_ANALOG_ADDR);
    wr_pwm_sel       = reg_wr_in && bdio_hit(reg_addr_in, bdio_pkg::PWM_SEL_ADDR);
  end

  // Read strobes, decoded the same way
  always_comb begin
    rd_wide_data     = reg_rd_in && bdio_hit(reg_addr_in, bdio_pkg::WIDE_DATA_ADDR);
    rd_wide_dir      = reg_rd_in && bdio_hit(reg_addr_in, bdio_pkg::WIDE_DIR_ADDR);
    rd_narrow_data   = reg_rd_in && bdio_hit(reg_addr_in, bdio_pkg::NARROW_DATA_ADDR);
    rd_narrow_dir    = reg_rd_in && bdio_hit(reg_addr_in, bdio_pkg::NARROW_DIR_ADDR);
    rd_wide_analog   = reg_rd_in && bdio_hit(reg_addr_in, bdio_pkg::WIDE_ANALOG_ADDR);
    rd_narrow_analog = reg_rd_in && bdio_hit(reg_addr_in, bdio_pkg::NARROW_ANALOG_ADDR);
    rd_pwm_sel       = reg_rd_in && bdio_hit(reg_addr_in, bdio_pkg::PWM_SEL_ADDR);
  end

  // Latch next values; whole-byte writes replace the sampled pins
  always_comb begin
    wide_merge        = bdio_merge(wide_view, reg_wdata_in, 8'h00);
    narrow_merge      = bdio_merge({4'h0, narrow_view}, reg_wdata_in, 8'h00);
    wide_latch_next   = wide_latch_reg;
    narrow_latch_next = narrow_latch_reg;
    if (wr_wide_data) begin
      wide_latch_next = wide_merge;
    end
    if (wr_narrow_data) begin
      narrow_latch_next = narrow_merge[3:0];
    end
  end

  // Direction next values; the input-only bit stays an input
  always_comb begin
    wide_dir_next   = wide_dir_reg;
    narrow_dir_next = narrow_dir_reg;
    if (wr_wide_dir) begin
      wide_dir_next = reg_wdata_in;
    end
    if (wr_narrow_dir) begin
      narrow_dir_next = reg_wdata_in[3:0];
    end
    narrow_dir_next[bdio_pkg::INPUT_ONLY_BIT] = 1'b1;
  end

  // Direction resets to all inputs on every reset
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      wide_dir_reg   <= bdio_pkg::WIDE_DIR_RST;
      narrow_dir_reg <= bdio_pkg::NARROW_DIR_RST;
    end else begin
      wide_dir_reg   <= wide_dir_next;
      narrow_dir_reg <= narrow_dir_next;
    end
  end

  // Analog select next values
  always_comb begin
    wide_analog_next   = wide_analog_reg;
    narrow_analog_next = narrow_analog_reg;
    if (wr_wide_analog) begin
      wide_analog_next = reg_wdata_in;
    end
    if (wr_narrow_analog) begin
      narrow_analog_next = reg_wdata_in[3:0];
    end
  end

  // Analog select resets to all analog, so pins read zero
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      wide_analog_reg   <= bdio_pkg::WIDE_ANALOG_RST;
      narrow_analog_reg <= bdio_pkg::NARROW_ANALOG_RST;
    end else begin
      wide_analog_reg   <= wide_analog_next;
      narrow_analog_reg <= narrow_analog_next;
    end
  end

  // PWM select next value
  always_comb begin
    pwm_sel_next = pwm_sel_reg;
    if (wr_pwm_sel) begin
      pwm_sel_next = reg_wdata_in[2:0];
    end
  end

  // PWM select resets to plain I/O
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      pwm_sel_reg <= bdio_pkg::PWM_SEL_RST;
    end else begin
      pwm_sel_reg <= pwm_sel_next;
    end
  end

  // Read data, one cycle after the strobe; zero otherwise
  always_comb begin
    rdata_next = 8'h00;
    if (rd_wide_data) begin
      rdata_next = wide_view;
    end
    if (rd_wide_dir) begin
      rdata_next = wide_dir_reg;
    end
    if (rd_narrow_data) begin
      rdata_next = {4'h0, narrow_view};
    end
    if (rd_narrow_dir) begin
      rdata_next = {4'h0, narrow_dir_reg};
    end
    if (rd_wide_analog) begin
      rdata_next = wide_analog_reg;
    end
    if (rd_narrow_analog) begin
      rdata_next = {4'h0, narrow_analog_reg};
    end
    if (rd_pwm_sel) begin
      rdata_next = {5'h00, pwm_sel_reg};
    end
  end

  // Read data register, cleared by any reset
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // Latches survive warm reset
  always_ff @(posedge clk_sys_in) begin
    if (!full_reset_n_in) begin
      wide_latch_reg   <= bdio_pkg::WIDE_LATCH_RST;
      narrow_latch_reg <= bdio_pkg::NARROW_LATCH_RST;
    end else if (!rst_n_in) begin
      wide_latch_reg   <= wide_latch_reg;
      narrow_latch_reg <= narrow_latch_reg;
    end else begin
      wide_latch_reg   <= wide_latch_next;
      narrow_latch_reg <= narrow_latch_next;
    end
  end

  // PWM sources in select-bit order
  assign pwm_src = {pwm_output_d_in, pwm_output_c_in, pwm_output_b_in};

  // Wide pins: low pins carry the latch, upper pins latch or PWM
  for (genvar gi = 0; gi < bdio_pkg::WIDE_W; gi++) begin : g_wide_pin
    if (gi < bdio_pkg::PWM_FIRST_BIT) begin : g_gpio
      // Plain general purpose pin
      assign wide_drive[gi] = wide_latch_reg[gi];
    end else begin : g_pwm
      // Select bit hands the pin to its PWM source
      assign wide_drive[gi] = pwm_sel_reg[gi-bdio_pkg::PWM_FIRST_BIT] ?
                              pwm_src[gi-bdio_pkg::PWM_FIRST_BIT] :
                              wide_latch_reg[gi];
    end
    // Driver on only while the direction bit is clear, analog or not
    assign wide_oe[gi] = ~wide_dir_reg[gi];
  end

  // Narrow pins two to zero; the input-only pin has no driver
  for (genvar gn = 0; gn < bdio_pkg::INPUT_ONLY_BIT; gn++) begin : g_narrow_pin
    assign narrow_drive[gn] = narrow_latch_reg[gn];
    assign narrow_oe[gn]    = ~narrow_dir_reg[gn];
  end

  // Port outputs
  assign wide_pin_out      = wide_drive;
  assign wide_pin_oe_out   = wide_oe;
  assign narrow_pin_out    = narrow_drive;
  assign narrow_pin_oe_out = narrow_oe;
  assign reg_rdata_out     = rdata_reg;
endmodule : bdio_ports

// ### dv/bdio_ports_assertions.sv
module bdio_chk (
  // Bus side
  input wire logic       clk_sys_in,
  input wire logic       rst_n_in,
  input wire logic [3:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic       reg_wr_in,
  input wire logic       reg_rd_in,
  input wire logic [7:0] reg_rdata_out,
  // Pin side
  input wire logic       master_clear_pin_enable_in,
  input wire logic [7:0] wide_pin_out,
  input wire logic [7:0] wide_pin_oe_out,
  input wire logic [2:0] narrow_pin_oe_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  // Driver enables follow direction writes; wide pins four to zero follow data writes
  wide_oe_a: assert property (reg_wr_in && reg_addr_in == 4'h1 |=>
    wide_pin_oe_out == ~$past(reg_wdata_in)) else $error("wide enable wrong");
  narrow_oe_a: assert property (reg_wr_in && reg_addr_in == 4'h3 |=>
    narrow_pin_oe_out == ~$past(reg_wdata_in[2:0])) else $error("narrow enable wrong");
  wide_latch_a: assert property (reg_wr_in && reg_addr_in == 4'h0 |=>
    wide_pin_out[4:0] == $past(reg_wdata_in[4:0])) else $error("latch not stored");
  // Read data of narrow and unmapped places
  ndir_read_a: assert property (reg_rd_in && reg_addr_in == 4'h3 |=>
    reg_rdata_out[7:3] == 5'h01) else $error("narrow direction bit three not one");
  ndata_high_a: assert property (reg_rd_in && reg_addr_in == 4'h2 |=>
    reg_rdata_out[7:4] == 4'h0) else $error("narrow upper bits not zero");
  mclr_read_a: assert property (reg_rd_in && reg_addr_in == 4'h2 &&
    master_clear_pin_enable_in |=> !reg_rdata_out[3]) else $error("input pin not zero");
  unmapped_read_a: assert property (reg_rd_in && reg_addr_in > 4'h6 |=>
    reg_rdata_out == 8'h00) else $error("unmapped read not zero");
  // Reset turns every driver off
  reset_dir_a: assert property (disable iff (1'b0) !rst_n_in |=>
    wide_pin_oe_out == 8'h00 && narrow_pin_oe_out == 3'h0) else $error("driver on in reset");
endmodule : bdio_chk

// ### dv/bdio_pins.sv
module bdio_pins (
  // Device drivers
  input  wire logic [7:0] wide_drv_in,
  input  wire logic [7:0] wide_oe_in,
  input  wire logic [2:0] narrow_drv_in,
  input  wire logic [2:0] narrow_oe_in,
  // Board levels
  input  wire logic [7:0] board_wide_in,
  input  wire logic [3:0] board_narrow_in,
  output logic      [7:0] wide_lvl_out,
  output logic      [3:0] narrow_lvl_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // Board yields where the device drives; bit three is board only
  assign wide_lvl_out   = (wide_oe_in & wide_drv_in) | (~wide_oe_in & board_wide_in);
  assign narrow_lvl_out = {board_narrow_in[3],
    (narrow_oe_in & narrow_drv_in) | (~narrow_oe_in & board_narrow_in[2:0])};
endmodule : bdio_pins

// ### dv/bdio_ports_tb.sv
module bdio_ports_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys_in = 1'b0, rst_n_in = 1'b0, full_reset_n_in = 1'b0;
  logic [3:0] reg_addr_in = 4'h0, bn = 4'h0, narrow_pin_in;
  logic [7:0] reg_wdata_in = 8'h00, bw = 8'h00, an, lat, reg_rdata_out, wide_pin_in;
  logic reg_wr_in = 1'b0, reg_rd_in = 1'b0, master_clear_pin_enable_in = 1'b0, pend = 1'b0;
  logic [2:0] pwm = 3'h0, narrow_pin_out, narrow_pin_oe_out;
  logic [7:0] wide_pin_out, wide_pin_oe_out, expq[$];
  logic [31:0] seed = 32'd89703;
  int fail_count = 0, checks = 0, cyc = 0;
  bdio_ports i_dut (.clk_sys_in, .rst_n_in, .full_reset_n_in, .reg_addr_in, .reg_wdata_in,
    .reg_wr_in, .reg_rd_in, .reg_rdata_out, .master_clear_pin_enable_in,
    .pwm_output_b_in(pwm[0]), .pwm_output_c_in(pwm[1]), .pwm_output_d_in(pwm[2]),
    .wide_pin_in, .wide_pin_out, .wide_pin_oe_out, .narrow_pin_in, .narrow_pin_out,
    .narrow_pin_oe_out);
  bdio_pins i_pins (.wide_drv_in(wide_pin_out), .wide_oe_in(wide_pin_oe_out),
    .narrow_drv_in(narrow_pin_out), .narrow_oe_in(narrow_pin_oe_out), .board_wide_in(bw),
    .board_narrow_in(bn), .wide_lvl_out(wide_pin_in), .narrow_lvl_out(narrow_pin_in));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic cmp(input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask : cmp
  task automatic wr8(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= 1'b1;
    @(posedge clk_sys_in);
    reg_wr_in <= 1'b0;
  endtask : wr8
  task automatic rd8(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk_sys_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    expq.push_back(exp);
    @(posedge clk_sys_in);
    reg_rd_in <= 1'b0;
  endtask : rd8
  task automatic settle();
    repeat (3) @(posedge clk_sys_in);
    #1;
  endtask : settle
  task automatic finish_test();
    $display("mismatches %0d comparisons %0d", fail_count, checks);
    if (fail_count == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : finish_test
  // Clock, read monitor and hang limit
  initial forever #5 clk_sys_in = ~clk_sys_in;
  always @(posedge clk_sys_in) pend <= reg_rd_in;
  always @(negedge clk_sys_in) if (pend) cmp(expq.pop_front(), reg_rdata_out);
  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      finish_test();
    end
  end
  // Main sequence
  initial begin
    repeat (12) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    full_reset_n_in <= 1'b1;
    bw <= 8'ha5;
    rd8(4'h1, 8'hff);
    rd8(4'h0, 8'h00);
    wr8(4'h5, 8'h00);
    for (int i = 0; i < 12; i++) begin
      seed = lfsr(lfsr(seed));
      an = i[0] ? seed[15:8] : 8'h00;
      lat = seed[23:16];
      bw <= seed[7:0];
      bn <= seed[11:8];
      master_clear_pin_enable_in <= seed[12];
      wr8(4'h4, an);
      wr8(4'h0, lat);
      wr8(4'h1, seed[31:24]);
      settle();
      cmp(~seed[31:24], wide_pin_oe_out);
      cmp({3'h0, lat[4:0]}, {3'h0, wide_pin_out[4:0]});
      rd8(4'h0, ((lat & ~seed[31:24]) | (bw & seed[31:24])) & ~an);
      rd8(4'h2, {4'h0, ~master_clear_pin_enable_in & bn[3], bn[2:0]});
    end
    wr8(4'h3, 8'h00);
    wr8(4'h2, 8'h05);
    rd8(4'h3, 8'h08);
    settle();
    cmp(8'h07, {5'h00, narrow_pin_oe_out});
    cmp(8'h05, {5'h00, narrow_pin_out});
    rd8(4'h2, {4'h0, ~master_clear_pin_enable_in & bn[3], 3'h5});
    for (int a = 7; a < 16; a++) rd8(a[3:0], 8'h00);
    wr8(4'h1, 8'h00);
    wr8(4'h6, 8'h07);
    pwm <= 3'h5;
    settle();
    cmp({3'h5, lat[4:0]}, wide_pin_out);
    wr8(4'h6, 8'h00);
    settle();
    cmp(lat, wide_pin_out);
    @(posedge clk_sys_in);
    rst_n_in <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    rd8(4'h1, 8'hff);
    wr8(4'h1, 8'h00);
    settle();
    cmp(lat, wide_pin_out);
    finish_test();
  end
endmodule : bdio_ports_tb

bind bdio_ports bdio_chk i_chk (.clk_sys_in, .rst_n_in, .reg_addr_in, .reg_wdata_in,
  .reg_wr_in, .reg_rd_in, .reg_rdata_out, .master_clear_pin_enable_in, .wide_pin_out,
  .wide_pin_oe_out, .narrow_pin_oe_out);
